/* File: bench/scd_coil_model.sv */
// file: behavioural coil and current sense model for one bridge
`timescale 1ns/10ps
module scd_coil_model
  import scd_pkg::*;
(
  input  wire logic        CLK,     // system clock
  input  wire logic        NRST,    // async reset, active low
  input  wire scd_bridge_t BRIDGE,  // bridge drive from the block
  input  wire logic        OPEN,    // 1: coil wire broken
  output logic             OVER     // sensed current above reference
);
  logic [CUR_W:0] cur;

  // ---------------------------------------------------------------------------
  // current rises while switched on, decays otherwise; open coil never rises
  // ---------------------------------------------------------------------------
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      cur <= '0;
    end else if (BRIDGE.enable && BRIDGE.pwm && !OPEN) begin
      cur <= cur + 9'h004;
    end else if (cur != '0) begin
      cur <= cur - 9'h001;
    end
  end

  // comparator seen by the regulator
  assign OVER = (cur > {1'b0, BRIDGE.ref_lvl});
endmodule

/* File: bench/scd_top_monitor.sv */
// file: concurrent checks on the coil drive protection ports
`timescale 1ns/10ps
module scd_top_monitor
  import scd_pkg::*;
(
  input wire logic             CLK,          // system clock
  input wire logic             NRST,         // async reset
  input wire logic             SETPOINT_WR,  // set-point pulse
  input wire logic             DECEL_DONE,   // deceleration end
  input wire logic             STATUS_QUERY, // status query
  input wire logic             FULL_QUERY,   // full status query
  input wire logic             LINK_LOST,    // link timeout
  input wire scd_bridge_t      BRIDGE_X,     // coil X drive
  input wire scd_bridge_t      BRIDGE_Y,     // coil Y drive
  input wire logic [POS_W-1:0] ACTUAL_POS,   // actual position
  input wire logic [POS_W-1:0] TARGET_POS,   // target position
  input wire scd_flags_t       FLAGS,        // fault flags
  input wire logic             SHUTDOWN,     // shutdown state
  input wire logic             BUSY,         // positioning
  input wire logic             SLEEP         // sleep state
);
  // ---------------------------------------------------------------------------
  // one clock domain, so clocking and reset are given once
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!NRST);

  property p_hiz; SHUTDOWN |-> !BRIDGE_X.enable && !BRIDGE_Y.enable; endproperty
  a_hiz: assert property (p_hiz) else $error("bridge driven in shutdown");
  property p_tgt; $rose(SHUTDOWN) |-> TARGET_POS == ACTUAL_POS; endproperty
  a_tgt: assert property (p_tgt) else $error("target not reloaded");
  property p_cause;
    FLAGS.pump_fail || FLAGS.coil_fault || FLAGS.overheat || FLAGS.low_battery
      |-> SHUTDOWN || SLEEP;
  endproperty
  a_cause: assert property (p_cause) else $error("fault without shutdown");
  property p_stop; FLAGS.pump_fail |-> FLAGS.abrupt_stop; endproperty
  a_stop: assert property (p_stop) else $error("pump fail w/o stop");
  property p_exit;
    $fell(SHUTDOWN) && !SLEEP |-> $past(STATUS_QUERY) || $past(FULL_QUERY);
  endproperty
  a_exit: assert property (p_exit) else $error("shutdown left unasked");
  property p_hold;
    $fell(SHUTDOWN) && !SLEEP |-> ##[0:1] (BRIDGE_X.enable || BRIDGE_Y.enable);
  endproperty
  a_hold: assert property (p_hold) else $error("no hold after exit");
  property p_sleep; SHUTDOWN && LINK_LOST |=> SLEEP; endproperty
  a_sleep: assert property (p_sleep) else $error("no sleep on link loss");
  property p_stab; DECEL_DONE && BUSY |=> (BUSY || SHUTDOWN) [*3]; endproperty
  a_stab: assert property (p_stab) else $error("settle cut short");
  property p_nomove;
    SHUTDOWN && SETPOINT_WR && !STATUS_QUERY && !FULL_QUERY |=> !BUSY;
  endproperty
  a_nomove: assert property (p_nomove) else $error("motion in shutdown");
  property p_noloss;
    SHUTDOWN && !FLAGS.missed_step |=> !FLAGS.missed_step;
  endproperty
  a_noloss: assert property (p_noloss) else $error("step loss flagged");
endmodule

bind scd_top scd_top_monitor u_mon (
  .CLK(CLK), .NRST(NRST), .SETPOINT_WR(SETPOINT_WR), .DECEL_DONE(DECEL_DONE),
  .STATUS_QUERY(STATUS_QUERY), .FULL_QUERY(FULL_QUERY), .LINK_LOST(LINK_LOST),
  .BRIDGE_X(BRIDGE_X), .BRIDGE_Y(BRIDGE_Y), .ACTUAL_POS(ACTUAL_POS),
  .TARGET_POS(TARGET_POS), .FLAGS(FLAGS), .SHUTDOWN(SHUTDOWN), .BUSY(BUSY),
  .SLEEP(SLEEP));

/* File: bench/scd_top_tb.sv */
// file: self-checking testbench of the coil drive protection block
`timescale 1ns/10ps
module scd_top_tb;
  import scd_pkg::*;
  logic             CLK, NRST, MICRO_MODE, SETPOINT_WR, DECEL_DONE, STEP_REQ;
  logic             STATUS_QUERY, FULL_QUERY, LINK_LOST, PUMP_LOW_IN;
  logic             over_x, over_y, SHUTDOWN, BUSY, SLEEP;
  logic [4:0]       flt;
  logic [1:0]       open_coil;
  logic [CUR_W-1:0] RUN_LEVEL, HOLD_LEVEL;
  logic [POS_W-1:0] SETPOINT, ACTUAL_POS, TARGET_POS;
  scd_bridge_t      BRIDGE_X, BRIDGE_Y;
  scd_flags_t       FLAGS, exp_f;
  int               err_total, total_checks, i;

  // short counts keep the run brief
  scd_top #(.STAB_CYC(24'h000004), .OPEN_CYC(24'h000040)) DUT (
    .CLK(CLK), .NRST(NRST), .MICRO_MODE(MICRO_MODE), .RUN_LEVEL(RUN_LEVEL),
    .HOLD_LEVEL(HOLD_LEVEL), .SETPOINT_WR(SETPOINT_WR), .SETPOINT(SETPOINT),
    .DECEL_DONE(DECEL_DONE), .STEP_REQ(STEP_REQ), .STATUS_QUERY(STATUS_QUERY),
    .FULL_QUERY(FULL_QUERY), .LINK_LOST(LINK_LOST), .OVERHEAT_IN(flt[0]),
    .TEMP_WARN_IN(flt[4]), .LOW_BATT_IN(flt[1]), .PUMP_LOW_IN(PUMP_LOW_IN),
    .SHORT_X_IN(flt[2]), .SHORT_Y_IN(flt[3]), .OVER_X_IN(over_x),
    .OVER_Y_IN(over_y), .BRIDGE_X(BRIDGE_X), .BRIDGE_Y(BRIDGE_Y),
    .ACTUAL_POS(ACTUAL_POS), .TARGET_POS(TARGET_POS), .FLAGS(FLAGS),
    .SHUTDOWN(SHUTDOWN), .BUSY(BUSY), .SLEEP(SLEEP));
  scd_coil_model u_cx (.CLK(CLK), .NRST(NRST), .BRIDGE(BRIDGE_X),
    .OPEN(open_coil[0]), .OVER(over_x));
  scd_coil_model u_cy (.CLK(CLK), .NRST(NRST), .BRIDGE(BRIDGE_Y),
    .OPEN(open_coil[1]), .OVER(over_y));

  // ---------------------------------------------------------------------------
  // clock, access tasks and report
  // ---------------------------------------------------------------------------
  initial begin
    CLK = 1'b0;
    forever #10 CLK = ~CLK;
  end

  task automatic cyc(input int n);
    repeat (n) @(negedge CLK);
  endtask

  // one-cycle pulse launched and dropped on falling edges
  task automatic pulse(ref logic s);
    @(negedge CLK);
    s = 1'b1;
    @(negedge CLK);
    s = 1'b0;
  endtask

  task automatic chk(input string n, input logic [15:0] e,
                     input logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic close_out;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // a query is sent once per attempt, never in a tight loop
  task automatic query_ok;
    pulse(STATUS_QUERY);
    cyc(2);
    chk("shutdown", 16'h0000, {15'h0, SHUTDOWN});
    chk("flags", 16'h0000, {9'h0, FLAGS});
  endtask

  // watchdog: slow duty ramp of the open coil test needs about 66000 cycles
  initial begin
    repeat (90000) @(posedge CLK);
    err_total++;
    close_out;
  end

  // ---------------------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------------------
  initial begin
    {NRST, MICRO_MODE, SETPOINT_WR, DECEL_DONE, STEP_REQ} = 5'h00;
    {STATUS_QUERY, FULL_QUERY, LINK_LOST, PUMP_LOW_IN} = 4'h0;
    flt = 5'h00;
    open_coil = 2'h0;
    RUN_LEVEL = 8'hc0;
    HOLD_LEVEL = 8'h40;
    SETPOINT = 16'h0000;
    err_total = 0;
    total_checks = 0;
    cyc(5);
    NRST = 1'b1;
    cyc(4);
    chk("reset shutdown", 16'h0001, {15'h0, SHUTDOWN});
    chk("reset enable", 16'h0000, {15'h0, BRIDGE_X.enable});
    pulse(FULL_QUERY);
    cyc(2);
    chk("exit", 16'h0000, {15'h0, SHUTDOWN});
    chk("hold enable", 16'h0001, {15'h0, BRIDGE_X.enable});
    // motion in half steps, then a refused set-point while settling
    SETPOINT = 16'h0010;
    pulse(SETPOINT_WR);
    cyc(1);
    chk("busy", 16'h0001, {15'h0, BUSY});
    chk("target", 16'h0010, TARGET_POS);
    for (i = 0; i < 3; i++) pulse(STEP_REQ);
    chk("actual", 16'h0003, ACTUAL_POS);
    pulse(DECEL_DONE);
    SETPOINT = 16'h0020;
    pulse(SETPOINT_WR);
    chk("stab busy", 16'h0001, {15'h0, BUSY});
    chk("stab target", 16'h0010, TARGET_POS);
    cyc(8);
    chk("idle", 16'h0000, {15'h0, BUSY});
    // pump failure during a micro-step motion
    MICRO_MODE = 1'b1;
    SETPOINT = 16'h0030;
    pulse(SETPOINT_WR);
    pulse(STEP_REQ);
    PUMP_LOW_IN = 1'b1;
    cyc(5);
    exp_f = '0;
    exp_f.pump_fail = 1'b1;
    exp_f.abrupt_stop = 1'b1;
    exp_f.missed_step = 1'b1;
    chk("pump flags", {9'h0, exp_f}, {9'h0, FLAGS});
    chk("pump sd", 16'h0001, {15'h0, SHUTDOWN});
    chk("sd target", 16'h0004, TARGET_POS);
    SETPOINT = 16'h0040;
    pulse(SETPOINT_WR);
    chk("sd busy", 16'h0000, {15'h0, BUSY});
    chk("sd target", 16'h0004, TARGET_POS);
    pulse(STATUS_QUERY);
    cyc(2);
    exp_f.missed_step = 1'b0;
    chk("kept flags", {9'h0, exp_f}, {9'h0, FLAGS});
    chk("kept sd", 16'h0001, {15'h0, SHUTDOWN});
    PUMP_LOW_IN = 1'b0;
    cyc(4);
    chk("sticky", {9'h0, exp_f}, {9'h0, FLAGS});
    query_ok();
    // each remaining fault pin in turn; warning alone keeps running
    for (i = 0; i < 5; i++) begin
      flt = 5'h01 << i;
      cyc(5);
      exp_f = '0;
      exp_f.overheat = (i == 0);
      exp_f.low_battery = (i == 1);
      exp_f.coil_fault = (i == 2) || (i == 3);
      exp_f.temp_warning = (i == 4);
      chk("pin flags", {9'h0, exp_f}, {9'h0, FLAGS});
      chk("pin sd", {15'h0, i < 4}, {15'h0, SHUTDOWN});
      chk("pin hiz", {15'h0, i == 4}, {15'h0, BRIDGE_Y.enable});
      flt = 5'h00;
      cyc(4);
      query_ok();
    end
    // both coils broken: full duty for a period must be caught
    open_coil = 2'h3;
    for (i = 0; i < 70000 && !SHUTDOWN; i++) cyc(1);
    chk("open fault", 16'h0001, {15'h0, FLAGS.coil_fault});
    LINK_LOST = 1'b1;
    cyc(2);
    chk("sleep", 16'h0001, {15'h0, SLEEP});
    chk("sleep busy", 16'h0000, {15'h0, BUSY});
    close_out;
  end
endmodule

/* File: inc/scd_pkg.sv */
// package: shared types and constants of the coil drive protection block
package scd_pkg;

  // ---------------------------------------------------------------------------
  // widths and timing
  // ---------------------------------------------------------------------------
  localparam int          POS_W          = 16;   // position register width
  localparam int          ANG_W          = 6;    // electrical angle, 64/period
  localparam int          CUR_W          = 8;    // current magnitude width
  localparam int          DUTY_W         = 8;    // pwm duty / counter width
  localparam int          CLK_HZ         = 50000000;
  localparam int          STAB_TIME_US   = 10;   // stabilization_time default
  localparam int          STAB_CYC_DEF   =
    (STAB_TIME_US * (CLK_HZ / 1000000));
  localparam int          OPEN_CYC_DEF   = 1000000; // open coil period default
  localparam int          CNT_W          = 24;
  localparam logic [ANG_W-1:0] HALF_INC  = 6'h08; // half step = 8/64 period
  localparam logic [ANG_W-1:0] MICRO_INC = 6'h01; // 1/16 micro step
  localparam logic [DUTY_W-1:0] DUTY_FULL = 8'hff;
  localparam logic [DUTY_W-1:0] DUTY_ZERO = 8'h00;
  localparam logic [CNT_W-1:0]  CNT_ZERO  = 24'h000000;
  localparam logic [CNT_W-1:0]  CNT_ONE   = 24'h000001;
  localparam logic [POS_W-1:0]  POS_ONE   = 16'h0001;

  // ---------------------------------------------------------------------------
  // motion states
  // ---------------------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_SHUTDOWN = 3'b000,
    ST_HOLD     = 3'b001,
    ST_RUN      = 3'b010,
    ST_STAB     = 3'b011,
    ST_SLEEP    = 3'b100
  } scd_state_t;

  // fault flags as seen by the status query
  typedef struct packed {
    logic temp_warning;
    logic overheat;
    logic low_battery;
    logic missed_step;
    logic coil_fault;
    logic pump_fail;
    logic abrupt_stop;
  } scd_flags_t;

  // raw fault conditions from the analog side
  typedef struct packed {
    logic temp_warning;
    logic overheat;
    logic low_battery;
    logic pump_low;
    logic short_x;
    logic short_y;
  } scd_cond_t;

  // bridge drive for one coil
  typedef struct packed {
    logic             enable;  // low puts the bridge in high impedance
    logic             pwm;     // switch on phase
    logic             dir;     // current polarity
    logic [CUR_W-1:0] ref_lvl; // reference magnitude
  } scd_bridge_t;

endpackage

/* File: logic/scd_pwm.sv */
// file: one coil current regulator with pwm output and open coil watch
`timescale 1ns/10ps
module scd_pwm
  import scd_pkg::*;
(
  input  wire logic             CLK,       // system clock
  input  wire logic             NRST,      // async reset, active low
  input  wire logic             ENABLE,    // bridge active
  input  wire logic [CUR_W-1:0] REF_LVL,   // target magnitude
  input  wire logic             OVER_REF,  // sensed current above target
  input  wire logic [CNT_W-1:0] OPEN_CYC,  // one electrical period in cycles
  output logic                  PWM,       // switch on phase
  output logic                  OPEN_COIL  // full duty for a whole period
);

  typedef struct packed {
    logic [DUTY_W-1:0] duty;
    logic [DUTY_W-1:0] phase;
    logic [CNT_W-1:0]  full_cnt;
    logic              pwm;
    logic              open;
  } scd_pwm_state_t;

  scd_pwm_state_t r;
  scd_pwm_state_t next_r;

  // ---------------------------------------------------------------------------
  // regulation
  // ---------------------------------------------------------------------------
  // duty steps once per pwm period; a slow loop but glitch free
  always_comb begin
    next_r = r;
    next_r.phase = r.phase + 8'h01;
    if (!ENABLE) begin
      next_r.duty = DUTY_ZERO;
      next_r.full_cnt = CNT_ZERO;
      next_r.pwm = 1'b0;
      next_r.open = 1'b0;
    end else begin
      if (r.phase == DUTY_FULL) begin
        // compare sensed current to reference, see RULE_02
        if (OVER_REF && r.duty != DUTY_ZERO)
          next_r.duty = r.duty - 8'h01;
        else if (!OVER_REF && r.duty != DUTY_FULL && REF_LVL != DUTY_ZERO)
          next_r.duty = r.duty + 8'h01;
      end
      next_r.pwm = (r.phase < r.duty) || (r.duty == DUTY_FULL);
      // count full duty; a whole period of it means open coil, see RULE_09
      if (r.duty == DUTY_FULL) begin
        if (r.full_cnt >= OPEN_CYC - CNT_ONE)
          next_r.open = 1'b1;  // see RULE_22
        else
          next_r.full_cnt = r.full_cnt + CNT_ONE;
      end else begin
        next_r.full_cnt = CNT_ZERO;
        next_r.open = 1'b0;
      end
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST)
      r <= '0;
    else
      r <= next_r;
  end

  assign PWM = r.pwm;
  assign OPEN_COIL = r.open;

endmodule

/* File: logic/scd_top.sv */
// file: coil sequencing, fault flags and motor shutdown control
// ---------------------------------------------------------------------------
// How it works
// RULE_01: coil X and Y follow sine and cosine, half step or 1/16 step
// RULE_02: pwm regulator compares sensed current to reference scaled by level
// RULE_03: motion start switches at once from hold to run current
// RULE_04: after deceleration currents hold at present level for stabilization
// RULE_05: then hold current at target angle, new orders accepted only after
// RULE_06: pump failure forces abrupt stop and sets the pump fail flag
// RULE_07: pump failure during motion also sets missed step flag
// RULE_08: bridge short opens that bridge and sets coil fault flag
// RULE_09: open coil when duty stays full for one electrical period
// RULE_10: overheat, low battery, pump fail or coil fault force shutdown
// RULE_11: shutdown puts both bridges in high impedance
// RULE_12: shutdown copies actual position into target position
// RULE_13: commands still accepted in shutdown, set-points cause no motion
// RULE_14: shutdown left only on status query with all causes gone
// RULE_15: leaving shutdown drives hold current, ready for positioning
// RULE_16: status query clears flags, persisting conditions set them again
// RULE_17: link loss in shutdown enters sleep at once
// RULE_18: no step loss flagged while in shutdown
// RULE_19: master should limit repeated queries that fail to leave shutdown
// RULE_20: flags clear only after a query and when the condition is gone; missed_step clears on any query
// RULE_21: shutdown kept until overheat and abrupt stop flags are clear
// RULE_22: stabilization and open coil periods are cycle counters
// ---------------------------------------------------------------------------
`timescale 1ns/10ps
module scd_top
  import scd_pkg::*;
#(
  parameter logic [CNT_W-1:0] STAB_CYC = CNT_W'(STAB_CYC_DEF), // settle
  parameter logic [CNT_W-1:0] OPEN_CYC = CNT_W'(OPEN_CYC_DEF)  // open watch
)(
  input  wire logic             CLK,          // system clock, 50 MHz
  input  wire logic             NRST,         // async reset, active low
  input  wire logic             MICRO_MODE,   // 1: 1/16 step, 0: half step
  input  wire logic [CUR_W-1:0] RUN_LEVEL,    // run current magnitude
  input  wire logic [CUR_W-1:0] HOLD_LEVEL,   // hold current magnitude
  input  wire logic             SETPOINT_WR,  // new target_position pulse
  input  wire logic [POS_W-1:0] SETPOINT,     // target_position value
  input  wire logic             DECEL_DONE,   // ramp reports deceleration end
  input  wire logic             STEP_REQ,     // ramp asks for one step
  input  wire logic             STATUS_QUERY, // status_query_cmd pulse
  input  wire logic             FULL_QUERY,   // full_status_query_cmd pulse
  input  wire logic             LINK_LOST,    // bus communication timeout
  input  wire logic             OVERHEAT_IN,  // thermal shutdown comparator
  input  wire logic             TEMP_WARN_IN, // temperature warning comparator
  input  wire logic             LOW_BATT_IN,  // below low_battery_level
  input  wire logic             PUMP_LOW_IN,  // charge pump too low
  input  wire logic             SHORT_X_IN,   // drop across bridge X switch
  input  wire logic             SHORT_Y_IN,   // drop across bridge Y switch
  input  wire logic             OVER_X_IN,    // coil X current above target
  input  wire logic             OVER_Y_IN,    // coil Y current above target
  output scd_bridge_t           BRIDGE_X,     // coil X bridge drive
  output scd_bridge_t           BRIDGE_Y,     // coil Y bridge drive
  output logic [POS_W-1:0]      ACTUAL_POS,   // actual_position
  output logic [POS_W-1:0]      TARGET_POS,   // target_position
  output scd_flags_t            FLAGS,        // flags for status answers
  output logic                  SHUTDOWN,     // motor shutdown active
  output logic                  BUSY,         // positioning in progress
  output logic                  SLEEP         // sleep state entered
);

  typedef struct packed {
    scd_cond_t         s1;
    scd_cond_t         s2;
    logic              ox1;
    logic              ox2;
    logic              oy1;
    logic              oy2;
    scd_state_t        state;
    scd_flags_t        flags;
    logic [POS_W-1:0]  act;
    logic [POS_W-1:0]  tag;
    logic [ANG_W-1:0]  angle;
    logic [CUR_W-1:0]  level;
    logic [CNT_W-1:0]  stab_cnt;
    logic              open_x;
    logic              open_y;
    scd_bridge_t       bx;
    scd_bridge_t       by;
  } scd_top_state_t;

  scd_top_state_t r;
  scd_top_state_t next_r;

  logic             pwm_x;
  logic             pwm_y;
  logic             open_x;
  logic             open_y;
  logic [CUR_W-1:0] sin_mag;
  logic [CUR_W-1:0] cos_mag;
  logic             sin_neg;
  logic             cos_neg;
  logic [ANG_W-1:0] next_angle_run;
  logic             query;
  logic             causes;
  logic             moving;

  // ---------------------------------------------------------------------------
  // sine table, one quadrant of 16 entries
  // ---------------------------------------------------------------------------
  function automatic logic [CUR_W-1:0] quarter_sine(input logic [3:0] idx);
    unique case (idx)
      4'h0: quarter_sine = 8'h00;
      4'h1: quarter_sine = 8'h19;
      4'h2: quarter_sine = 8'h32;
      4'h3: quarter_sine = 8'h4a;
      4'h4: quarter_sine = 8'h62;
      4'h5: quarter_sine = 8'h78;
      4'h6: quarter_sine = 8'h8e;
      4'h7: quarter_sine = 8'ha2;
      4'h8: quarter_sine = 8'hb5;
      4'h9: quarter_sine = 8'hc6;
      4'ha: quarter_sine = 8'hd5;
      4'hb: quarter_sine = 8'he2;
      4'hc: quarter_sine = 8'hed;
      4'hd: quarter_sine = 8'hf5;
      4'he: quarter_sine = 8'hfb;
      4'hf: quarter_sine = 8'hfe;
    endcase
  endfunction

  // full period sine with sign, from the quadrant and mirrored index
  function automatic logic [CUR_W:0] sine_of(input logic [ANG_W-1:0] a);
    logic [3:0] idx;
    idx = a[4] ? (a[3:0] == 4'h0 ? 4'hf : 4'h0 - a[3:0]) : a[3:0];
    if (a[4] && a[3:0] == 4'h0)
      sine_of = {a[5], 8'hff};
    else
      sine_of = {a[5], quarter_sine(idx)};
  endfunction

  // scale magnitude by current level, keeps the coil ratio
  function automatic logic [CUR_W-1:0] scale(input logic [CUR_W-1:0] m,
                                             input logic [CUR_W-1:0] l);
    logic [2*CUR_W-1:0] p;
    p = m * l;
    scale = p[2*CUR_W-1:CUR_W];
  endfunction

  // ---------------------------------------------------------------------------
  // coil angle to currents
  // ---------------------------------------------------------------------------
  // x follows sine, y cosine (a quarter period ahead), see RULE_01
  always_comb begin
    {sin_neg, sin_mag} = sine_of(r.angle);
    {cos_neg, cos_mag} = sine_of(r.angle + 6'h10);
  end

  // step size picks the profile, see RULE_01
  assign next_angle_run = r.angle + (MICRO_MODE ? MICRO_INC : HALF_INC);
  assign query  = STATUS_QUERY || FULL_QUERY;
  // physical causes seen now, not the latched flags, see RULE_14
  assign causes = r.s2.overheat || r.s2.low_battery || r.s2.pump_low ||
                  r.s2.short_x || r.s2.short_y || r.open_x || r.open_y;
  assign moving = (r.state == ST_RUN);

  // ---------------------------------------------------------------------------
  // regulators for both coils
  // ---------------------------------------------------------------------------
  scd_pwm u_pwm_x (
    .CLK       (CLK),
    .NRST      (NRST),
    .ENABLE    (r.bx.enable),
    .REF_LVL   (r.bx.ref_lvl),
    .OVER_REF  (r.ox2),
    .OPEN_CYC  (OPEN_CYC),
    .PWM       (pwm_x),
    .OPEN_COIL (open_x)
  );

  scd_pwm u_pwm_y (
    .CLK       (CLK),
    .NRST      (NRST),
    .ENABLE    (r.by.enable),
    .REF_LVL   (r.by.ref_lvl),
    .OVER_REF  (r.oy2),
    .OPEN_CYC  (OPEN_CYC),
    .PWM       (pwm_y),
    .OPEN_COIL (open_y)
  );

  // ---------------------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------------------
  always_comb begin
    next_r = r;
    // pins pass two flip-flops before use
    next_r.s1 = {TEMP_WARN_IN, OVERHEAT_IN, LOW_BATT_IN, PUMP_LOW_IN,
                 SHORT_X_IN, SHORT_Y_IN};
    next_r.s2 = r.s1;
    next_r.ox1 = OVER_X_IN;
    next_r.ox2 = r.ox1;
    next_r.oy1 = OVER_Y_IN;
    next_r.oy2 = r.oy1;
    next_r.open_x = open_x;
    next_r.open_y = open_y;

    // query clears flags whose condition is gone and missed_step always, see RULE_16
    if (query) begin
      if (!r.s2.temp_warning) next_r.flags.temp_warning = 1'b0; // see RULE_20
      if (!r.s2.overheat)     next_r.flags.overheat     = 1'b0;
      if (!r.s2.low_battery)  next_r.flags.low_battery  = 1'b0;
      if (!r.s2.pump_low)     next_r.flags.pump_fail    = 1'b0;
      if (!(r.s2.short_x || r.s2.short_y || r.open_x || r.open_y))
        next_r.flags.coil_fault = 1'b0;
      next_r.flags.missed_step = 1'b0;
      if (!r.s2.pump_low)     next_r.flags.abrupt_stop  = 1'b0;
    end
    // set wins over clear for every flag
    if (r.s2.temp_warning) next_r.flags.temp_warning = 1'b1;
    if (r.s2.overheat)     next_r.flags.overheat     = 1'b1;
    if (r.s2.low_battery)  next_r.flags.low_battery  = 1'b1;
    if (r.s2.pump_low) begin
      next_r.flags.pump_fail   = 1'b1;                 // see RULE_06
      next_r.flags.abrupt_stop = 1'b1;
      if (moving)
        next_r.flags.missed_step = 1'b1;               // see RULE_07
    end
    if (r.s2.short_x || r.s2.short_y || r.open_x || r.open_y)
      next_r.flags.coil_fault = 1'b1;                  // see RULE_08

    // shorted bridge opened at once, the coil fault shutdown opens the other in the same cycle, see RULE_08
    if (r.s2.short_x) next_r.bx.enable = 1'b0;
    if (r.s2.short_y) next_r.by.enable = 1'b0;

    unique case (r.state)
      ST_SHUTDOWN: begin
        // set-points are ignored and target is held at actual, so they never move the motor, see RULE_13
        next_r.tag = r.act;
        next_r.bx.enable = 1'b0;
        next_r.by.enable = 1'b0;
        if (LINK_LOST)
          next_r.state = ST_SLEEP;                      // see RULE_17
        else if (query && !causes) begin
          // exit on query with causes gone, see RULE_14 and RULE_21
          next_r.state = ST_HOLD;                       // see RULE_15
          next_r.level = HOLD_LEVEL;
          next_r.bx.enable = 1'b1;
          next_r.by.enable = 1'b1;
        end
      end
      ST_HOLD: begin
        next_r.level = HOLD_LEVEL;
        if (LINK_LOST)
          next_r.state = ST_SLEEP;
        else if (SETPOINT_WR && SETPOINT != r.act) begin
          next_r.tag = SETPOINT;
          next_r.state = ST_RUN;
          next_r.level = RUN_LEVEL;                     // see RULE_03
          next_r.angle = next_angle_run;                // first step ratio
        end
      end
      ST_RUN: begin
        next_r.level = RUN_LEVEL;
        if (SETPOINT_WR)
          next_r.tag = SETPOINT;
        if (STEP_REQ && r.act != r.tag) begin
          next_r.angle = next_angle_run;
          next_r.act = r.act + POS_ONE;
        end
        if (DECEL_DONE) begin
          next_r.state = ST_STAB;                       // see RULE_04
          next_r.stab_cnt = CNT_ZERO;
        end
      end
      ST_STAB: begin
        // level and angle frozen while settling, see RULE_22
        if (r.stab_cnt >= STAB_CYC - CNT_ONE) begin
          next_r.state = ST_HOLD;                       // see RULE_05
          next_r.level = HOLD_LEVEL;
        end else
          next_r.stab_cnt = r.stab_cnt + CNT_ONE;
      end
      ST_SLEEP: begin
        next_r.bx.enable = 1'b0;
        next_r.by.enable = 1'b0;
      end
      default: next_r.state = ST_SHUTDOWN;
    endcase

    // any cause forces shutdown from the motion states, see RULE_10
    if (r.state != ST_SHUTDOWN && r.state != ST_SLEEP &&
        (next_r.flags.overheat || next_r.flags.low_battery ||
         next_r.flags.pump_fail || next_r.flags.coil_fault)) begin
      next_r.state = ST_SHUTDOWN;
      next_r.bx.enable = 1'b0;                          // see RULE_11
      next_r.by.enable = 1'b0;
      next_r.tag = r.act;                               // see RULE_12
    end
    // no missed step is raised in shutdown, see RULE_18
    if (r.state == ST_SHUTDOWN && !r.flags.missed_step)
      next_r.flags.missed_step = 1'b0;

    // bridge drive follows angle and level
    next_r.bx.pwm = pwm_x;
    next_r.by.pwm = pwm_y;
    next_r.bx.dir = sin_neg;
    next_r.by.dir = cos_neg;
    next_r.bx.ref_lvl = scale(sin_mag, r.level);        // see RULE_02
    next_r.by.ref_lvl = scale(cos_mag, r.level);
  end

  // ---------------------------------------------------------------------------
  // state register; power-on starts in shutdown
  // ---------------------------------------------------------------------------
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST)
      r <= '0;
    else
      r <= next_r;
  end

  assign BRIDGE_X   = r.bx;
  assign BRIDGE_Y   = r.by;
  assign ACTUAL_POS = r.act;
  assign TARGET_POS = r.tag;
  assign FLAGS      = r.flags;
  assign SHUTDOWN   = (r.state == ST_SHUTDOWN);
  assign BUSY       = r.state[1];
  assign SLEEP      = r.state[2];

endmodule
